/* logic/rtc_irq_adjust_ctrl.v */
// interrupt request flags, extension window, read flag, adjust and stop control
// assumes addr/data/strobes are synchronous to clk; strobes are one cycle long
`timescale 1ns/1ps
`default_nettype none
`include "rtc_ctrl_map.vh"

// Operation
// R1: alarm mode bit chooses held low request (1) or low pulse (0) when unmasked
// R2: alarm event raised when alarm equals counter over selected compare range
// R3: alarm pulse mode holds output low for about 61 us
// R4: periodic flag reads 1 while periodic output low, 0 while open
// R5: unmasked periodic expiry drives output low and sets flag together
// R6: periodic interrupt mode: flag and low output persist until read clears
// R7: data protect: read within 122 us defers clear to 122 us after event
// R8: read at least 122 us after event clears immediately even with protect
// R9: interrupt mode ignores writing 0 and ignores new events while flag set
// R10: periodic pulse mode clears by writing 0 or restoration time; read keeps
// R11: unmasked alarm match drives alarm output low and sets flag together
// R12: alarm interrupt mode: read clears, write 0 ignored, repeat alarm ignored
// R13: alarm pulse mode clears by writing 0 or after 61 us; read keeps
// R14: sub-second reset bit holds fraction counter reset until 0 written
// R15: chip select low clears sub-second reset; writing 1 clears test bits
// R16: window flag is 1 in interrupt mode, protect set, under 122 us
// R17: window flag read-only, not cleared by read
// R18: seconds carry sets read flag; read clears it; repeat carry keeps 1
// R19: any 30 s adjustment also sets read flag
// R20: adjust write starts adjustment; time registers locked for 125 us
// R21: adjust bit self-clears within 250 us
// R22: hardware adjust input also sets adjust bit with same self-clear
// R23: periodic mask 0 enables periodic output, 1 disables it
// R24: interval code selects 1/1024 s up to 10 min period
module rtc_irq_adjust_ctrl #(
  parameter integer WIN_CYC   = `EXT_WINDOW_CYC,
  parameter integer APULS_CYC = `ALARM_PULSE_CYC,
  parameter integer LOCK_CYC  = `ADJ_LOCK_CYC,
  parameter integer HOLD_CYC  = `ADJ_HOLD_CYC,
  parameter integer TICK_DIV  = `TICK_1024_DIV
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [3:0] addr,
  input  wire [3:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  input  wire       primary_chip_select,
  input  wire       periodic_mask_bit,
  input  wire       alarm_mask_bit,
  input  wire       periodic_output_mode_bit,
  input  wire       alarm_output_mode_bit,
  input  wire       interval_code_bit2,
  input  wire       interval_code_bit1,
  input  wire       interval_code_bit0,
  input  wire       data_protect_bit,
  input  wire       alarm_equal,
  input  wire       seconds_carry,
  input  wire       adjust_in,
  input  wire       stop_in,
  input  wire       stop_source_select,
  output reg  [3:0] rdata_r,
  output reg        periodic_out_r,
  output reg        periodic_out_oe_r,
  output reg        alarm_out_r,
  output reg        alarm_out_oe_r,
  output reg        subsecond_reset_r,
  output reg        test_bits_clear_r,
  output reg        adjust_start_r,
  output reg        time_access_lock_r,
  output reg        clock_stop_r
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // data protect blocks every write to these two registers
  wire       wr_ok    = wr_stb & ~data_protect_bit;
  wire       wr_e     = wr_ok & (addr == `ADDR_INT_STATUS_CTRL);
  wire       wr_f     = wr_ok & (addr == `ADDR_CLK_ADJUST_CTRL);
  wire       rd_e     = rd_stb & (addr == `ADDR_INT_STATUS_CTRL);
  wire       rd_f     = rd_stb & (addr == `ADDR_CLK_ADJUST_CTRL);
  wire [2:0] icode    = {interval_code_bit2, interval_code_bit1, interval_code_bit0};

  // ----------------------------------------------------------------
  // periodic interval timebase
  // ----------------------------------------------------------------
  reg  [17:0] pre_r;
  reg  [19:0] per_r;
  reg  [19:0] per_len;
  reg  [31:0] subsecond_reset_bit_len;
  wire        tick      = (pre_r == TICK_DIV[17:0] - 18'h00001);
  // a shorter code takes effect at once: a count already past the new end
  // closes the interval at the next tick instead of running round 2^20 ticks
  wire        per_done  = tick & (per_r >= per_len - 20'h00001);

  always @* begin
    case (icode) // [R24]
      3'h0:    per_len = 20'h00001;
      3'h1:    per_len = 20'h00008;
      3'h2:    per_len = 20'h00010;
      3'h3:    per_len = 20'h00040;
      3'h4:    per_len = 20'h00200;
      3'h5:    per_len = 20'h00400;
      3'h6:    per_len = 20'h0f000;
      default: per_len = 20'h96000;
    endcase
    // half period low for short codes, one window length for the long ones
    if (icode <= 3'h4) begin // [R10]
      subsecond_reset_bit_len = (TICK_DIV * {12'h000, per_len}) >> 1;
    end else begin
      subsecond_reset_bit_len = WIN_CYC;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pre_r <= 18'h00000;
      per_r <= 20'h00000;
    end else begin
      pre_r <= tick ? 18'h00000 : pre_r + 18'h00001;
      if (per_done) begin
        per_r <= 20'h00000;
      end else if (tick) begin
        per_r <= per_r + 20'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // request flags, source 0 periodic, source 1 alarm
  // ----------------------------------------------------------------
  reg         alarm_eq_d_r;
  wire [1:0]  evt;
  wire [1:0]  int_mode  = {alarm_output_mode_bit, periodic_output_mode_bit};
  wire [1:0]  flag;
  wire [1:0]  flag_next;
  wire [1:0]  in_win;
  wire [31:0] rlen [0:1];

  // alarm compare range is resolved upstream; only the rising match counts
  assign evt[0]  = per_done & ~periodic_mask_bit;               // [R5] [R23]
  assign evt[1]  = alarm_equal & ~alarm_eq_d_r & ~alarm_mask_bit; // [R2] [R11]
  assign rlen[0] = subsecond_reset_bit_len;
  assign rlen[1] = APULS_CYC; // [R3]

  always @(posedge clk) begin
    if (!rst_n) begin
      alarm_eq_d_r <= 1'b0;
    end else begin
      alarm_eq_d_r <= alarm_equal;
    end
  end

  // ----------------------------------------------------------------
  // per-source flag state
  // ----------------------------------------------------------------
  // the pin enable is registered from the next flag value, so the read-back
  // bit and the pin never disagree, not even for the cycle of a clear
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : src
      reg        flag_r;
      reg        flag_nxt;
      reg        pend_r;
      reg        pend_nxt;
      reg [15:0] win_r;
      reg [31:0] rst_cnt_r;
      wire       set_now = evt[g] & ~flag_r;
      assign flag[g]      = flag_r;
      assign flag_next[g] = flag_nxt;
      assign in_win[g]    = (win_r != 16'h0000);
      always @* begin
        flag_nxt = flag_r;
        pend_nxt = pend_r;
        if (set_now) begin
          // events while the flag stands are dropped
          flag_nxt = 1'b1; // [R5] [R11] [R9] [R12]
          pend_nxt = 1'b0;
        end else if (int_mode[g]) begin
          if (rd_e && data_protect_bit && in_win[g]) begin
            pend_nxt = 1'b1; // [R7]
          end else if (rd_e) begin
            flag_nxt = 1'b0; // [R6] [R8] [R12]
            pend_nxt = 1'b0;
          end else if (pend_r && win_r == 16'h0001) begin
            flag_nxt = 1'b0; // [R7]
            pend_nxt = 1'b0;
          end
        end else begin
          pend_nxt = 1'b0;
          // reads leave the flag alone in pulse mode
          if (wr_e && !wdata[g]) begin
            flag_nxt = 1'b0; // [R10] [R13]
          end else if (flag_r && rst_cnt_r == 32'h00000001) begin
            flag_nxt = 1'b0; // [R3] [R10] [R13]
          end
        end
      end
      always @(posedge clk) begin
        if (!rst_n) begin
          flag_r    <= 1'b0;
          pend_r    <= 1'b0;
          win_r     <= 16'h0000;
          rst_cnt_r <= 32'h00000000;
        end else begin
          flag_r <= flag_nxt;
          pend_r <= pend_nxt;
          if (set_now) begin
            win_r     <= WIN_CYC[15:0];
            rst_cnt_r <= rlen[g];
          end else begin
            if (in_win[g]) begin
              win_r <= win_r - 16'h0001;
            end
            if (!int_mode[g] && rst_cnt_r != 32'h00000000) begin
              rst_cnt_r <= rst_cnt_r - 32'h00000001;
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pins, window flag, read flag, adjust, stop, sub-second reset
  // ----------------------------------------------------------------
  reg        ext_win_r;
  reg        read_flag_r;
  reg        stop_bit_r;
  reg        adj_in_d_r;
  reg [15:0] adj_cnt_r;
  wire       adj_go = (wr_f & wdata[`BIT_ADJUST]) | (adjust_in & ~adj_in_d_r);

  always @(posedge clk) begin
    if (!rst_n) begin
      periodic_out_r     <= 1'b0;
      periodic_out_oe_r  <= 1'b0;
      alarm_out_r        <= 1'b0;
      alarm_out_oe_r     <= 1'b0;
      ext_win_r          <= 1'b0;
      read_flag_r        <= 1'b0;
      stop_bit_r         <= 1'b0;
      adj_in_d_r         <= 1'b0;
      adj_cnt_r          <= 16'h0000;
      adjust_start_r     <= 1'b0;
      time_access_lock_r <= 1'b0;
      clock_stop_r       <= 1'b0;
      subsecond_reset_r  <= `SUBSEC_RESET_RST;
      test_bits_clear_r  <= 1'b0;
    end else begin
      // open drain: pin pulled low exactly while its flag stands
      periodic_out_r    <= 1'b0;
      periodic_out_oe_r <= flag_next[0]; // [R4] [R5]
      alarm_out_r       <= 1'b0;
      alarm_out_oe_r    <= flag_next[1]; // [R1] [R11]
      ext_win_r <= data_protect_bit & |(int_mode & in_win); // [R16] [R17]
      // a carry in the same cycle as the read keeps the flag set
      if (seconds_carry || adj_go) begin
        read_flag_r <= 1'b1; // [R18] [R19]
      end else if (rd_f) begin
        read_flag_r <= 1'b0; // [R18]
      end
      // hardware adjust is edge-taken so a held input starts one adjustment
      adj_in_d_r     <= adjust_in;
      adjust_start_r <= adj_go;
      if (adj_go) begin
        adj_cnt_r <= HOLD_CYC[15:0]; // [R20] [R22]
      end else if (adj_cnt_r != 16'h0000) begin
        adj_cnt_r <= adj_cnt_r - 16'h0001; // [R21]
      end
      // lock covers the first 125 us of the hold
      time_access_lock_r <= adj_go | (adj_cnt_r > HOLD_CYC[15:0] - LOCK_CYC[15:0] + 16'h0001); // [R20]
      if (wr_f) begin
        stop_bit_r <= wdata[`BIT_STOP];
      end
      clock_stop_r <= stop_source_select ? stop_in : stop_bit_r;
      if (!primary_chip_select) begin
        subsecond_reset_r <= 1'b0; // [R15]
      end else if (wr_e) begin
        subsecond_reset_r <= wdata[`BIT_SUBSEC_RESET]; // [R14]
      end
      test_bits_clear_r <= wr_e & wdata[`BIT_SUBSEC_RESET]; // [R15]
    end
  end

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  // the window flag has no write path, so host writes to bit 3 fall away
  // unmapped reads return zero so a stray address never shows stale data
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 4'h0;
    end else if (rd_e) begin
      rdata_r <= {ext_win_r, subsecond_reset_r, flag[1], flag[0]}; // [R4] [R17]
    end else if (rd_f) begin
      rdata_r <= {1'b0, stop_bit_r, (adj_cnt_r != 16'h0000), read_flag_r}; // [R21]
    end else if (rd_stb) begin
      rdata_r <= 4'h0;
    end
  end

endmodule // rtc_irq_adjust_ctrl
`default_nettype wire

/* logic/rtc_ctrl_map.vh */
// constants for the interrupt flag and adjust control block
// assumes a 250 MHz core clock and a 4-bit parallel register port
`ifndef RTC_CTRL_MAP_VH
`define RTC_CTRL_MAP_VH

// ----------------------------------------------------------------
// register addresses and bit positions
// ----------------------------------------------------------------
`define ADDR_INT_STATUS_CTRL  4'he
`define ADDR_CLK_ADJUST_CTRL  4'hf
`define BIT_PERIODIC_FLAG     0
`define BIT_ALARM_FLAG        1
`define BIT_SUBSEC_RESET      2
`define BIT_EXT_WINDOW        3
`define BIT_READ_FLAG         0
`define BIT_ADJUST            1
`define BIT_STOP              2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ                250000000
`define CLK_PERIOD_NS         4
`define EXT_WINDOW_US         122
`define ALARM_PULSE_US        61
`define ADJ_LOCK_US           125
`define ADJ_HOLD_US           250
`define EXT_WINDOW_CYC        ((`EXT_WINDOW_US * 1000) / `CLK_PERIOD_NS)
`define ALARM_PULSE_CYC       ((`ALARM_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define ADJ_LOCK_CYC          ((`ADJ_LOCK_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADJ_HOLD_CYC          ((`ADJ_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define TICK_1024_DIV         (`CLK_HZ / 1024)
`define SUBSEC_RESET_RST      1'b0

`endif

/* verif/host_model.sv */
// host model: parallel register master for the flag block
// assumes strobes are sampled on the clk rising edge, rdata_r one edge later
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  output logic      [3:0] addr,
  output logic      [3:0] wdata,
  output logic            wr_stb,
  output logic            rd_stb,
  input  wire logic [3:0] rdata_r
);
  initial begin
    {addr, wdata, wr_stb, rd_stb} = 10'h0;
  end
  task automatic wr(input logic [3:0] a, input logic [3:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    wdata <= ~v; // released data must not look like a held value
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [3:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata_r;
  endtask
endmodule // host_model
`default_nettype wire

/* verif/irq_chk_checker.sv */
// checker: port relations of the flag and adjust block
// assumes one clock domain and the short bench parameters
`timescale 1ns/1ps
`default_nettype none
module irq_chk #(
  parameter int APULS_CYC = 10,
  parameter int LOCK_CYC  = 10
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] addr,
  input wire logic [3:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic       primary_chip_select,
  input wire logic       periodic_mask_bit,
  input wire logic       alarm_mask_bit,
  input wire logic       alarm_output_mode_bit,
  input wire logic       data_protect_bit,
  input wire logic       alarm_equal,
  input wire logic       adjust_in,
  input wire logic [3:0] rdata_r,
  input wire logic       periodic_out_r,
  input wire logic       periodic_out_oe_r,
  input wire logic       alarm_out_r,
  input wire logic       alarm_out_oe_r,
  input wire logic       subsecond_reset_r,
  input wire logic       test_bits_clear_r,
  input wire logic       adjust_start_r,
  input wire logic       time_access_lock_r
);
  int acnt;
  int lcnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // counters keep long spans out of repetition operators
  always @(posedge clk) begin
    acnt <= (alarm_out_oe_r && !alarm_output_mode_bit) ? acnt + 1 : 0;
    lcnt <= time_access_lock_r ? lcnt + 1 : 0;
  end
  sequence alarm_rise;
    $rose(alarm_equal) && !alarm_mask_bit && !alarm_out_oe_r;
  endsequence
  a_alarm_sets: assert property (alarm_rise |=> alarm_out_oe_r)
    else $error("alarm output not taken low");
  a_alarm_masked: assert property (alarm_mask_bit && !alarm_out_oe_r |=> !alarm_out_oe_r)
    else $error("masked alarm drove output");
  a_pulse_len: assert property (acnt <= APULS_CYC + 1)
    else $error("alarm pulse too long");
  a_lock_len: assert property (lcnt <= LOCK_CYC + 2)
    else $error("access lock too long");
  a_flag_readback: assert property (rd_stb && addr == 4'he
    |=> rdata_r[1:0] == $past({alarm_out_oe_r, periodic_out_oe_r}))
    else $error("flag differs from output");
  a_unmapped_zero: assert property (rd_stb && addr < 4'he |=> rdata_r == 4'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rd_stb |=> $stable(rdata_r))
    else $error("read data moved");
  a_test_clear: assert property (wr_stb && addr == 4'he && wdata[2] && !data_protect_bit
    |=> test_bits_clear_r)
    else $error("test bits not cleared");
  a_subsec_cs: assert property (!primary_chip_select && !wr_stb |=> !subsecond_reset_r)
    else $error("chip select did not clear");
  a_mask_quiet: assert property (periodic_mask_bit && !periodic_out_oe_r
    |=> !periodic_out_oe_r)
    else $error("masked periodic output");
  a_pin_low: assert property (!periodic_out_r && !alarm_out_r)
    else $error("pin drive value not low");
  a_dp_blocks: assert property (wr_stb && data_protect_bit && !adjust_in |=> !adjust_start_r)
    else $error("protected write started adjust");
endmodule // irq_chk
bind rtc_irq_adjust_ctrl irq_chk #(.APULS_CYC(APULS_CYC), .LOCK_CYC(LOCK_CYC)) chk_i (.*);
`default_nettype wire

/* verif/rtc_irq_flags_and_adjust_control_tb_top.sv */
// bench: directed scenarios for flags, window, read flag, adjust and stop
// assumes host_model on the register port and the checker bound to the dut
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_flags_and_adjust_control_tb_top;
  logic       clk, rst_n, wr_stb, rd_stb, primary_chip_select, periodic_mask_bit;
  logic       alarm_mask_bit, periodic_output_mode_bit, alarm_output_mode_bit;
  logic       interval_code_bit2, interval_code_bit1, interval_code_bit0, data_protect_bit;
  logic       alarm_equal, seconds_carry, adjust_in, stop_in, stop_source_select;
  logic       periodic_out_r, periodic_out_oe_r, alarm_out_r, alarm_out_oe_r, clock_stop_r;
  logic       subsecond_reset_r, test_bits_clear_r, adjust_start_r, time_access_lock_r;
  logic [3:0] addr, wdata, rdata_r, d;
  int         fail_count, cmp_count, n, c;
  int         per[5] = '{1, 8, 16, 64, 512};
  host_model h (.*);
  rtc_irq_adjust_ctrl #(.WIN_CYC(20), .APULS_CYC(10), .LOCK_CYC(10), .HOLD_CYC(20),
    .TICK_DIV(8)) dut (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic ev;
    @(posedge clk) alarm_equal <= 1'b1;
    @(posedge clk) alarm_equal <= 1'b0;
    #1;
  endtask
  // cycles until the periodic output next goes active, bounded
  task automatic rise(output int k);
    k = 0;
    while (periodic_out_oe_r !== 1'b0 && k < 9000) begin cyc(1); k++; end
    while (periodic_out_oe_r !== 1'b1 && k < 9000) begin cyc(1); k++; end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_alarm;
    ev;
    chk(alarm_out_oe_r, 0);
    @(posedge clk) alarm_mask_bit <= 1'b0;
    ev;
    chk(alarm_out_oe_r, 1);
    h.wr(4'he, 4'h0);
    ev;
    chk(alarm_out_oe_r, 1);
    h.rd(4'he, d);
    chk(d & 4'h2, 4'h2);
    cyc(1);
    chk(alarm_out_oe_r, 0);
    @(posedge clk) alarm_output_mode_bit <= 1'b0;
    ev;
    h.rd(4'he, d);
    h.rd(4'he, d);
    chk(d & 4'h2, 4'h2);
    chk(alarm_out_oe_r, 1);
    cyc(12);
    chk(alarm_out_oe_r, 0);
    ev;
    h.wr(4'he, 4'h0);
    cyc(1);
    chk(alarm_out_oe_r, 0);
  endtask
  task automatic t_protect;
    @(posedge clk) alarm_output_mode_bit <= 1'b1;
    @(posedge clk) data_protect_bit <= 1'b1;
    ev;
    h.rd(4'he, d);
    h.rd(4'he, d);
    chk(d, 4'ha);
    chk(alarm_out_oe_r, 1);
    cyc(20);
    chk(alarm_out_oe_r, 0);
    h.rd(4'he, d);
    chk(d, 4'h0);
    ev;
    cyc(24);
    chk(alarm_out_oe_r, 1);
    h.rd(4'he, d);
    cyc(1);
    chk(alarm_out_oe_r, 0);
    h.wr(4'hf, 4'h2);
    h.rd(4'hf, d);
    chk(d & 4'h2, 4'h0);
    @(posedge clk) data_protect_bit <= 1'b0;
  endtask
  task automatic t_periodic;
    @(posedge clk) periodic_mask_bit <= 1'b0;
    rise(n);
    h.rd(4'he, d);
    chk(d & 4'h1, 4'h1);
    cyc(1);
    chk(periodic_out_oe_r, 0);
    rise(n);
    h.wr(4'he, 4'h0);
    chk(periodic_out_oe_r, 1);
    @(posedge clk) periodic_output_mode_bit <= 1'b0;
    for (c = 0; c < 5; c++) begin
      @(posedge clk) {interval_code_bit2, interval_code_bit1, interval_code_bit0} <= c[2:0];
      rise(n);
      rise(n);
      chk_n(n, per[c] * 8);
    end
    rise(n);
    h.rd(4'he, d);
    chk(periodic_out_oe_r, 1);
    h.wr(4'he, 4'h0);
    cyc(1);
    chk(periodic_out_oe_r, 0);
    // shortest interval, so an unmasked source would fire several times here
    @(posedge clk) begin
      periodic_mask_bit <= 1'b1;
      {interval_code_bit2, interval_code_bit1, interval_code_bit0} <= 3'h0;
    end
    cyc(40);
    chk(periodic_out_oe_r, 0);
  endtask
  task automatic chk_n(input int g, input int e);
    cmp_count++;
    if (g != e) begin
      fail_count++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task automatic t_control;
    h.wr(4'he, 4'h4);
    #1 chk(test_bits_clear_r, 1);
    h.rd(4'he, d);
    chk({d[2], subsecond_reset_r}, 4'h3);
    h.wr(4'he, 4'h0);
    cyc(1);
    chk(subsecond_reset_r, 0);
    h.wr(4'he, 4'h4);
    @(posedge clk) primary_chip_select <= 1'b0;
    cyc(2);
    chk(subsecond_reset_r, 0);
    @(posedge clk) primary_chip_select <= 1'b1;
    @(posedge clk) seconds_carry <= 1'b1;
    @(posedge clk) seconds_carry <= 1'b1;
    @(posedge clk) seconds_carry <= 1'b0;
    h.rd(4'hf, d);
    chk(d & 4'h1, 4'h1);
    h.rd(4'hf, d);
    chk(d & 4'h1, 4'h0);
    h.wr(4'hf, 4'h2);
    cyc(1);
    chk(time_access_lock_r, 1);
    for (c = 0; c < 2; c++) begin
      h.rd(4'hf, d);
      chk(d & 4'h3, 4'h3);
      // host keeps off the time registers until the adjust bit drops
      for (n = 0; n < 14 && d[1]; n++) h.rd(4'hf, d);
      chk({d[1], time_access_lock_r}, 4'h0);
      @(posedge clk) adjust_in <= 1'b1;
      cyc(2);
    end
    h.wr(4'hf, 4'h4);
    h.rd(4'h3, d);
    chk(d, 4'h0);
    chk(clock_stop_r, 1);
    @(posedge clk) stop_source_select <= 1'b1;
    cyc(2);
    chk(clock_stop_r, 0);
  endtask
  initial begin
    {rst_n, primary_chip_select, periodic_mask_bit, alarm_mask_bit} = 4'h7;
    {periodic_output_mode_bit, alarm_output_mode_bit, interval_code_bit2} = 3'h6;
    {interval_code_bit1, interval_code_bit0, data_protect_bit, alarm_equal} = 4'h0;
    {seconds_carry, adjust_in, stop_in, stop_source_select} = 4'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_alarm;
    t_protect;
    t_periodic;
    t_control;
    finish_test;
  end
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end
endmodule // rtc_irq_flags_and_adjust_control_tb_top
`default_nettype wire
